// file: hdl/jcmd_top.sv
/*
  jcmd_top: jack clamp logic, general switch control and microphone impedance
  detect sequencer behind an AXI4-Lite register slave.
  Assumes the analogue front end answers a request with one done pulse on the
  same clock; jack sense, gpio5 and the 32 kHz clock arrive as raw pins.
*/
// Notes on behaviour
// - clamp code 0 disables, code 1 forces clamp on, 2 and 3 reserved
// - codes 4 to 7 clamp on jack low, jack high, gpio5 low, gpio5 high
// - codes 8 to B clamp when jack or gpio5 matches its level
// - codes C to F clamp only when jack and gpio5 both match
// - switch code 00 keeps switch open, 01 keeps it closed
// - switch code 10 closes while clamped, 11 closes while unclamped
// - raw status bit 3 shows the clamp state, read only
// - discrete mode reports one of 8 levels, ADC mode a 7-bit value
// - selected bias output turns on by itself while detecting
// - sense pin select routes detection to pin a or pin b
// - reference select picks mic supply or one of three bias outputs
// - detection runs when enabled with mode 000 or 111
// - measurements repeat with the programmed gap between them
// - discrete result accepted after 2 or 4 equal measurements
// - valid flag sets on settled result, holds while enabled, fields follow
// - level tests 0 to 4 and 7 enabled or skipped by their mask bits, tests 5 and 6 always off
// - ADC mode stores latest value and difference from previous
// - jack and clamp debounce run on 32 kHz ticks
// - clamp rise and fall each give a maskable event
// - interval codes 0 continuous, then 0.25 ms doubling to 512 ms
module jcmd_top #(
  parameter int unsigned BASE_STEP = jcmd_pkg::BASE_STEP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire jcmd_pkg::jcmd_axi_req_t axi_req,
  output jcmd_pkg::jcmd_axi_rsp_t axi_rsp,
  input wire logic jack_sense_signal,
  input wire logic gpio5_input_signal,
  input wire logic clk32_pin,
  input wire jcmd_pkg::jcmd_meas_t meas,
  output jcmd_pkg::jcmd_ana_t ana,
  output logic clamp_rise_event,
  output logic clamp_fall_event
);

  typedef struct packed {
    logic [2:0] jk_sync;
    logic [2:0] gp_sync;
    logic [2:0] ck_sync;
    logic jk_f;
    logic gp_f;
    logic ck_f;
    logic jack_db;
    logic [1:0] jack_cnt;
    logic clamp;
    logic [1:0] clamp_cnt;
    logic [3:0] clamp_mode;
    logic [1:0] sw_mode;
    logic jd_db_en;
    logic cl_db_en;
    logic acc_src;
    logic [2:0] acc_mode;
    logic [3:0] start_time;
    logic [3:0] rate;
    logic [1:0] ref_sel;
    logic db4;
    logic det_en;
    logic [7:0] lvl_mask;
    logic [1:0] evt_en;
    jcmd_pkg::jcmd_state_t state;
    logic [31:0] wait_cnt;
    logic [2:0] last_lvl;
    logic [2:0] same_cnt;
    logic valid;
    logic present;
    logic [2:0] level;
    logic [6:0] adc_val;
    logic [7:0] adc_delta;
    logic have_prev;
    jcmd_pkg::jcmd_ana_t ana;
    logic rise_evt;
    logic fall_evt;
    logic aw_ok;
    logic w_ok;
    logic [15:0] awaddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    jcmd_pkg::jcmd_axi_rsp_t rsp;
  } jcmd_regs_t;

  jcmd_regs_t r;
  jcmd_regs_t nxt;

  function automatic logic clamp_eval(input logic [3:0] code, input logic jk, input logic gp);
    logic res;
    res = 1'b0;
    case (code[3:2])
      2'b00: res = (code[1:0] == 2'h1);
      2'b01: res = code[1] ? (gp == code[0]) : (jk == code[0]);
      2'b10: res = (jk == code[1]) || (gp == code[0]);
      default: res = (jk == code[1]) && (gp == code[0]);
    endcase
    return res;
  endfunction

  function automatic logic [31:0] gap_cycles(input logic [3:0] code, input int unsigned base);
    logic [31:0] res;
    res = 32'h0;
    if (code == 4'h0) begin
      res = 32'h0;
    end else if (code > jcmd_pkg::RATE_CODE_MAX) begin
      res = 32'(base) << 11;
    end else begin
      res = 32'(base) << (code - 4'h1);
    end
    return res;
  endfunction

  logic running;
  logic clamp_raw;
  logic ck_tick;
  logic [13:0] widx;
  logic [13:0] ridx;
  logic [15:0] rword;
  logic rhit;
  logic whit;
  logic [2:0] cnt_inc;

  always_comb begin
    nxt = r;
    running = 1'b0;
    clamp_raw = 1'b0;
    ck_tick = 1'b0;
    rword = 16'h0;
    rhit = 1'b1;
    whit = 1'b1;
    cnt_inc = 3'h0;
    widx = r.awaddr[15:2];
    ridx = axi_req.araddr[15:2];
    nxt.rise_evt = 1'b0;
    nxt.fall_evt = 1'b0;

    // pins: three stages, a change counts once stages two and three agree
    nxt.jk_sync = {r.jk_sync[1:0], jack_sense_signal};
    nxt.gp_sync = {r.gp_sync[1:0], gpio5_input_signal};
    nxt.ck_sync = {r.ck_sync[1:0], clk32_pin};
    if (r.jk_sync[1] == r.jk_sync[2]) begin
      nxt.jk_f = r.jk_sync[2];
    end
    if (r.gp_sync[1] == r.gp_sync[2]) begin
      nxt.gp_f = r.gp_sync[2];
    end
    if (r.ck_sync[1] == r.ck_sync[2]) begin
      nxt.ck_f = r.ck_sync[2];
    end
    ck_tick = nxt.ck_f && !r.ck_f;

    if (!r.jd_db_en || r.jk_f == r.jack_db) begin
      nxt.jack_db = r.jk_f;
      nxt.jack_cnt = 2'h0;
    end else if (ck_tick) begin
      nxt.jack_cnt = r.jack_cnt + 2'h1;
      if (nxt.jack_cnt == jcmd_pkg::DB_TICKS) begin
        nxt.jack_db = r.jk_f;
        nxt.jack_cnt = 2'h0;
      end
    end

    clamp_raw = clamp_eval(r.clamp_mode, r.jack_db, r.gp_f);
    // clamp debounce on 32 kHz ticks
    if (!r.cl_db_en || clamp_raw == r.clamp) begin
      nxt.clamp = clamp_raw;
      nxt.clamp_cnt = 2'h0;
    end else if (ck_tick) begin
      nxt.clamp_cnt = r.clamp_cnt + 2'h1;
      if (nxt.clamp_cnt == jcmd_pkg::DB_TICKS) begin
        nxt.clamp = clamp_raw;
        nxt.clamp_cnt = 2'h0;
      end
    end
    nxt.rise_evt = nxt.clamp && !r.clamp && r.evt_en[0];
    nxt.fall_evt = !nxt.clamp && r.clamp && r.evt_en[1];

    case (r.sw_mode)
      2'h0: nxt.ana.switch_closed = 1'b0;
      2'h1: nxt.ana.switch_closed = 1'b1;
      2'h2: nxt.ana.switch_closed = r.clamp;
      default: nxt.ana.switch_closed = !r.clamp;
    endcase
    nxt.ana.clamp_short = r.clamp;

    // detection runs only in the two mic modes
    running = r.det_en && (r.acc_mode == jcmd_pkg::MODE_DISCRETE ||
      r.acc_mode == jcmd_pkg::MODE_ADC);
    if (!running) begin
      nxt.state = jcmd_pkg::JCMD_IDLE;
      nxt.ana.meas_req = 1'b0;
      nxt.valid = 1'b0;
      nxt.have_prev = 1'b0;
      nxt.same_cnt = 3'h0;
    end else begin
      case (r.state)
        jcmd_pkg::JCMD_IDLE: begin
          nxt.state = jcmd_pkg::JCMD_MEASURE;
          nxt.ana.meas_req = 1'b1;
        end
        jcmd_pkg::JCMD_MEASURE: begin
          if (meas.done) begin
            nxt.ana.meas_req = 1'b0;
            // gap from end of one measurement to next start
            nxt.wait_cnt = gap_cycles(r.rate, BASE_STEP);
            nxt.state = jcmd_pkg::JCMD_WAIT;
            if (r.acc_mode == jcmd_pkg::MODE_ADC) begin
              nxt.adc_val = meas.adc;
              nxt.adc_delta = {1'b0, meas.adc} - {1'b0, r.adc_val};
              nxt.have_prev = 1'b1;
              // valid once two samples give a difference
              nxt.valid = r.valid || r.have_prev;
            end else begin
              cnt_inc = (r.same_cnt == 3'h7) ? r.same_cnt : r.same_cnt + 3'h1;
              nxt.same_cnt = (r.have_prev && meas.level == r.last_lvl) ? cnt_inc : 3'h1;
              nxt.last_lvl = meas.level;
              nxt.have_prev = 1'b1;
              if (nxt.same_cnt >= (r.db4 ? 3'h4 : 3'h2)) begin
                nxt.level = meas.level;
                nxt.present = !meas.none;
                nxt.valid = 1'b1;
              end
            end
          end
        end
        jcmd_pkg::JCMD_WAIT: begin
          if (r.wait_cnt <= 32'h1) begin
            nxt.state = jcmd_pkg::JCMD_MEASURE;
            nxt.ana.meas_req = 1'b1;
            nxt.wait_cnt = 32'h0;
          end else begin
            nxt.wait_cnt = r.wait_cnt - 32'h1;
          end
        end
        default: nxt.state = jcmd_pkg::JCMD_IDLE;
      endcase
    end

    // bias turned on for the chosen reference while detecting
    nxt.ana.bias_output_enable = 3'h0;
    if (nxt.state != jcmd_pkg::JCMD_IDLE && r.ref_sel != 2'h0) begin
      nxt.ana.bias_output_enable = 3'(3'h1 << (r.ref_sel - 2'h1));
    end
    nxt.ana.detect_reference_select = r.ref_sel;
    nxt.ana.sense_pin_select = r.acc_src;
    // per-level test enables; unused bits forced off
    nxt.ana.level_enable_mask = r.lvl_mask & 8'h9F;
    nxt.ana.adc_mode = (r.acc_mode == jcmd_pkg::MODE_ADC);

    // bus write side: address and data accepted in either order
    if (axi_req.awvalid && r.rsp.awready) begin
      nxt.aw_ok = 1'b1;
      nxt.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && r.rsp.wready) begin
      nxt.w_ok = 1'b1;
      nxt.wdata = axi_req.wdata[15:0];
      nxt.wstrb = axi_req.wstrb[1:0];
    end
    if (r.rsp.bvalid && axi_req.bready) begin
      nxt.rsp.bvalid = 1'b0;
    end
    if (r.aw_ok && r.w_ok && !r.rsp.bvalid) begin
      nxt.aw_ok = 1'b0;
      nxt.w_ok = 1'b0;
      nxt.rsp.bvalid = 1'b1;
      if (widx == jcmd_pkg::IDX_CLAMP_CTRL) begin
        if (r.wstrb[0]) nxt.clamp_mode = r.wdata[3:0];
      end else if (widx == jcmd_pkg::IDX_SWITCH_CTRL) begin
        if (r.wstrb[0]) nxt.sw_mode = r.wdata[1:0];
      end else if (widx == jcmd_pkg::IDX_DEBOUNCE_CTRL) begin
        if (r.wstrb[0]) begin
          nxt.jd_db_en = r.wdata[jcmd_pkg::POS_JACK_DB];
          nxt.cl_db_en = r.wdata[jcmd_pkg::POS_CLAMP_DB];
        end
      end else if (widx == jcmd_pkg::IDX_ACC_MODE) begin
        if (r.wstrb[0]) nxt.acc_mode = r.wdata[2:0];
        if (r.wstrb[1]) nxt.acc_src = r.wdata[jcmd_pkg::POS_SENSE_SEL];
      end else if (widx == jcmd_pkg::IDX_MIC_DET1) begin
        if (r.wstrb[0]) begin
          nxt.det_en = r.wdata[0];
          nxt.db4 = r.wdata[jcmd_pkg::POS_DBTIME];
          nxt.ref_sel = r.wdata[jcmd_pkg::POS_REF_SEL +: 2];
        end
        if (r.wstrb[1]) begin
          nxt.rate = r.wdata[jcmd_pkg::POS_RATE +: 4];
          nxt.start_time = r.wdata[jcmd_pkg::POS_START_TIME +: 4];
        end
      end else if (widx == jcmd_pkg::IDX_MIC_DET2) begin
        if (r.wstrb[0]) nxt.lvl_mask = r.wdata[7:0];
      end else if (widx == jcmd_pkg::IDX_EVENT_MASK) begin
        if (r.wstrb[0]) nxt.evt_en = r.wdata[1:0];
      end else if (widx == jcmd_pkg::IDX_RAW_STATUS || widx == jcmd_pkg::IDX_RESULT ||
        widx == jcmd_pkg::IDX_ADC_RESULT) begin
        whit = 1'b1;
      end else begin
        whit = 1'b0;
      end
      nxt.rsp.bresp = whit ? jcmd_pkg::RESP_OKAY : jcmd_pkg::RESP_SLVERR;
    end
    nxt.rsp.awready = !nxt.aw_ok && !nxt.rsp.bvalid;
    nxt.rsp.wready = !nxt.w_ok && !nxt.rsp.bvalid;

    // bus read side
    if (r.rsp.rvalid && axi_req.rready) begin
      nxt.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && r.rsp.arready) begin
      if (ridx == jcmd_pkg::IDX_CLAMP_CTRL) begin
        rword = {12'h0, r.clamp_mode};
      end else if (ridx == jcmd_pkg::IDX_SWITCH_CTRL) begin
        rword = {14'h0, r.sw_mode};
      end else if (ridx == jcmd_pkg::IDX_RAW_STATUS) begin
        // clamp flag, jack flag set on a low sense pin
        rword[jcmd_pkg::POS_CLAMP_STS] = r.clamp;
        rword[jcmd_pkg::POS_JACK_STS] = !r.jack_db;
      end else if (ridx == jcmd_pkg::IDX_DEBOUNCE_CTRL) begin
        rword[jcmd_pkg::POS_CLAMP_DB] = r.cl_db_en;
        rword[jcmd_pkg::POS_JACK_DB] = r.jd_db_en;
      end else if (ridx == jcmd_pkg::IDX_ACC_MODE) begin
        rword[jcmd_pkg::POS_SENSE_SEL] = r.acc_src;
        rword[2:0] = r.acc_mode;
      end else if (ridx == jcmd_pkg::IDX_MIC_DET1) begin
        rword = {r.start_time, r.rate, 2'h0, r.ref_sel, 2'h0, r.db4, r.det_en};
      end else if (ridx == jcmd_pkg::IDX_MIC_DET2) begin
        rword = {8'h0, r.lvl_mask};
      end else if (ridx == jcmd_pkg::IDX_RESULT) begin
        rword = {11'h0, r.level, r.present, r.valid};
      end else if (ridx == jcmd_pkg::IDX_ADC_RESULT) begin
        rword = {r.adc_delta, 1'b0, r.adc_val};
      end else if (ridx == jcmd_pkg::IDX_EVENT_MASK) begin
        rword = {14'h0, r.evt_en};
      end else begin
        rhit = 1'b0;
      end
      nxt.rsp.rvalid = 1'b1;
      nxt.rsp.rdata = {16'h0, rword};
      nxt.rsp.rresp = rhit ? jcmd_pkg::RESP_OKAY : jcmd_pkg::RESP_SLVERR;
    end
    nxt.rsp.arready = !nxt.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.state <= jcmd_pkg::JCMD_IDLE;
      r.rate <= jcmd_pkg::RST_RATE;
      r.start_time <= jcmd_pkg::RST_START_TIME;
      r.db4 <= jcmd_pkg::RST_DBTIME;
      r.lvl_mask <= jcmd_pkg::RST_LEVEL_MASK;
      r.jack_db <= 1'b1;
      r.jk_f <= 1'b1;
      r.jk_sync <= 3'h7;
    end else if (ce) begin
      r <= nxt;
    end
  end

  assign axi_rsp = r.rsp;
  assign ana = r.ana;
  assign clamp_rise_event = r.rise_evt;
  assign clamp_fall_event = r.fall_evt;

  property p_switch_open;
    @(posedge aclk) disable iff (!aresetn)
    ce && r.sw_mode == 2'h0 |=> !r.ana.switch_closed;
  endproperty
  a_switch_open: assert property (p_switch_open) else $error("switch not open");

  property p_switch_clamp;
    @(posedge aclk) disable iff (!aresetn)
    ce && r.sw_mode == 2'h3 |=> r.ana.switch_closed == !$past(r.clamp);
  endproperty
  a_switch_clamp: assert property (p_switch_clamp) else $error("switch not inverse of clamp");

  property p_clamp_force;
    @(posedge aclk) disable iff (!aresetn)
    ce && r.clamp_mode == 4'h1 && !r.cl_db_en |=> r.clamp ##1 !$past(ce) || r.ana.clamp_short;
  endproperty
  a_clamp_force: assert property (p_clamp_force) else $error("forced clamp missing");

  property p_clamp_and;
    @(posedge aclk) disable iff (!aresetn)
    ce && r.clamp_mode == 4'hF && !r.cl_db_en |=> r.clamp == ($past(r.jack_db) && $past(r.gp_f));
  endproperty
  a_clamp_and: assert property (p_clamp_and) else $error("and condition wrong");

  property p_valid_drop;
    @(posedge aclk) disable iff (!aresetn)
    ce && !r.det_en |=> !r.valid && !r.ana.meas_req;
  endproperty
  a_valid_drop: assert property (p_valid_drop) else $error("valid held while disabled");

  property p_adc_delta;
    @(posedge aclk) disable iff (!aresetn)
    ce && r.det_en && r.acc_mode == 3'h7 && r.state == jcmd_pkg::JCMD_MEASURE && meas.done
    |=> r.adc_val == $past(meas.adc) &&
        r.adc_delta == 8'({1'b0, $past(meas.adc)} - {1'b0, $past(r.adc_val)});
  endproperty
  a_adc_delta: assert property (p_adc_delta) else $error("adc difference wrong");

  property p_bias_auto;
    @(posedge aclk) disable iff (!aresetn)
    r.state != jcmd_pkg::JCMD_IDLE && r.ref_sel == 2'h2 && $stable(r.ref_sel)
    |-> r.ana.bias_output_enable == 3'h2;
  endproperty
  a_bias_auto: assert property (p_bias_auto) else $error("bias not enabled");

  property p_gap_continuous;
    @(posedge aclk) disable iff (!aresetn)
    ce && running && r.rate == 4'h0 && r.state == jcmd_pkg::JCMD_WAIT
    |=> r.state == jcmd_pkg::JCMD_MEASURE && r.ana.meas_req;
  endproperty
  a_gap_continuous: assert property (p_gap_continuous) else $error("continuous gap");

  property p_bresp_hold;
    @(posedge aclk) disable iff (!aresetn)
    r.rsp.bvalid && !axi_req.bready |=> r.rsp.bvalid && $stable(r.rsp.bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write answer dropped");
endmodule

// file: hdl/jcmd_pkg.sv
/*
  jcmd_pkg: register indices, field positions, reset values, timing constants
  and carrier structs for the jack clamp and mic detect block.
  Assumes a 125 MHz register clock and an AXI4-Lite master with 32-bit data.
*/
package jcmd_pkg;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_ACC_MODE = 14'h0293;
  localparam logic [13:0] IDX_CLAMP_CTRL = 14'h02A2;
  localparam logic [13:0] IDX_MIC_DET1 = 14'h02A3;
  localparam logic [13:0] IDX_MIC_DET2 = 14'h02A4;
  localparam logic [13:0] IDX_RESULT = 14'h02A5;
  localparam logic [13:0] IDX_ADC_RESULT = 14'h02A6;
  localparam logic [13:0] IDX_EVENT_MASK = 14'h02A7;
  localparam logic [13:0] IDX_SWITCH_CTRL = 14'h0C18;
  localparam logic [13:0] IDX_RAW_STATUS = 14'h0D55;
  localparam logic [13:0] IDX_DEBOUNCE_CTRL = 14'h0D56;

  // field positions
  localparam int POS_JACK_STS = 0;
  localparam int POS_CLAMP_STS = 3;
  localparam int POS_JACK_DB = 0;
  localparam int POS_CLAMP_DB = 3;
  localparam int POS_SENSE_SEL = 13;
  localparam int POS_DBTIME = 1;
  localparam int POS_REF_SEL = 4;
  localparam int POS_RATE = 8;
  localparam int POS_START_TIME = 12;

  // values after reset
  localparam logic [3:0] RST_RATE = 4'h1;
  localparam logic [3:0] RST_START_TIME = 4'h1;
  localparam logic RST_DBTIME = 1'b1;
  localparam logic [7:0] RST_LEVEL_MASK = 8'h9F;

  // detect modes and bus answers
  localparam logic [2:0] MODE_DISCRETE = 3'h0;
  localparam logic [2:0] MODE_ADC = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing: 0.25 ms base step of the measurement interval
  localparam int CLK_PERIOD_PS = 8000;
  localparam int BASE_STEP_US_X100 = 25000;
  localparam int BASE_STEP_CYCLES = (BASE_STEP_US_X100 * 10) / (CLK_PERIOD_PS / 1000);
  localparam logic [3:0] RATE_CODE_MAX = 4'hB;
  localparam logic [1:0] DB_TICKS = 2'h2;

  typedef enum logic [1:0] {
    JCMD_IDLE = 2'b00,
    JCMD_MEASURE = 2'b01,
    JCMD_WAIT = 2'b10
  } jcmd_state_t;

  typedef struct packed {
    logic [15:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [15:0] araddr;
    logic arvalid;
    logic rready;
  } jcmd_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } jcmd_axi_rsp_t;

  // answer of the analogue impedance front end, same clock domain
  typedef struct packed {
    logic done;
    logic [2:0] level;
    logic none;
    logic [6:0] adc;
  } jcmd_meas_t;

  // controls toward the analogue side
  typedef struct packed {
    logic meas_req;
    logic adc_mode;
    logic sense_pin_select;
    logic [1:0] detect_reference_select;
    logic [2:0] bias_output_enable;
    logic [7:0] level_enable_mask;
    logic clamp_short;
    logic switch_closed;
  } jcmd_ana_t;
endpackage

// file: verification/jcmd_front_model.sv
/*
  jcmd_front_model: behavioural analogue impedance front end.
  Assumes ana.meas_req holds until done is seen; the bench sets the answer.
*/
module jcmd_front_model #(
  parameter int DLY = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire jcmd_pkg::jcmd_ana_t ana,
  input wire logic [2:0] lvl,
  input wire logic none,
  input wire logic [6:0] adc_v,
  output jcmd_pkg::jcmd_meas_t meas
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic [6:0] pat = 7'h00;
  always @(posedge aclk) begin
    pat <= pat + 7'h01;
    if (!aresetn || !ana.meas_req) begin
      cnt <= 0;
    end else if (cnt <= DLY) begin
      cnt <= cnt + 1;
    end
  end
  // outside done the level and adc lines move every cycle and none every eight cycles, so stale values cannot pass
  always_comb begin
    meas.done = (cnt == DLY);
    meas.level = meas.done ? lvl : pat[2:0];
    meas.none = meas.done ? none : pat[3];
    meas.adc = meas.done ? adc_v : pat;
  end
endmodule

// file: verification/jcmd_top_tb.sv
/*
  jcmd_top_tb: register-level bench for the jack clamp and mic detect block.
  Assumes jcmd_front_model on the analogue side; ce is tied high.
*/
module jcmd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic jack = 1'b1;
  logic gpio_pin = 1'b0;
  logic clk32 = 1'b0;
  logic [2:0] lvl = 3'h3;
  logic [6:0] adc_v = 7'h30;
  jcmd_pkg::jcmd_axi_req_t req;
  jcmd_pkg::jcmd_axi_rsp_t rsp;
  jcmd_pkg::jcmd_meas_t meas;
  jcmd_pkg::jcmd_ana_t ana;
  logic rise_e;
  logic fall_e;
  int mismatches = 0;
  int checks_done = 0;
  int rise_n = 0;
  int fall_n = 0;
  int n;
  int r0;
  int f0;
  logic [15:0] q;
  logic [1:0] r;
  logic [13:0] ridx [6] = '{jcmd_pkg::IDX_CLAMP_CTRL, jcmd_pkg::IDX_SWITCH_CTRL,
    jcmd_pkg::IDX_RAW_STATUS, jcmd_pkg::IDX_DEBOUNCE_CTRL, jcmd_pkg::IDX_MIC_DET1,
    jcmd_pkg::IDX_MIC_DET2};
  logic [15:0] rval [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1102, 16'h009F};

  jcmd_top #(.BASE_STEP(4)) u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .axi_req(req), .axi_rsp(rsp), .jack_sense_signal(jack), .gpio5_input_signal(gpio_pin),
    .clk32_pin(clk32), .meas(meas), .ana(ana), .clamp_rise_event(rise_e),
    .clamp_fall_event(fall_e));
  jcmd_front_model u_front (.aclk(aclk), .aresetn(aresetn), .ana(ana), .lvl(lvl),
    .none(1'b0), .adc_v(adc_v), .meas(meas));

  initial begin
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (rise_e === 1'b1) rise_n <= rise_n + 1;
    if (fall_e === 1'b1) fall_n <= fall_n + 1;
  end

  task automatic summarize();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tmo();
    mismatches++;
    summarize();
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // one transfer; valid and payload hold until their own ready edge
  task automatic bus(input logic w, input logic [13:0] i, input logic [15:0] d,
    output logic [15:0] dq, output logic [1:0] rs);
    int c;
    @(posedge aclk);
    if (w) begin
      req.awaddr <= {i, 2'b00};
      req.wdata <= {16'h0000, d};
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
    end else begin
      req.araddr <= {i, 2'b00};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
    end
    c = 0;
    do begin
      @(posedge aclk);
      c++;
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && rsp.rvalid !== 1'b1 && c < 200);
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    dq = rsp.rdata[15:0];
    rs = w ? rsp.bresp : rsp.rresp;
    if (c >= 200) tmo();
  endtask
  task automatic wr(input logic [13:0] i, input logic [15:0] d);
    logic [15:0] dq;
    logic [1:0] rs;
    bus(1'b1, i, d, dq, rs);
    chk(16'(rs), 16'(jcmd_pkg::RESP_OKAY));
  endtask
  task automatic rd(input logic [13:0] i, output logic [15:0] dq);
    logic [1:0] rs;
    bus(1'b0, i, 16'h0000, dq, rs);
    chk(16'(rs), 16'(jcmd_pkg::RESP_OKAY));
  endtask
  task automatic waitreq(input logic v, output int c);
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (ana.meas_req !== v && c < 2000);
    if (c >= 2000) tmo();
  endtask
  function automatic logic clamp_exp(logic [3:0] c, logic jd, logic gp);
    case (c[3:2])
      2'b00: return c == 4'h1;
      2'b01: return c[1] ? (gp == c[0]) : (jd == c[0]);
      default: return c[2] ? ((jd == c[1]) && (gp == c[0])) : ((jd == c[1]) || (gp == c[0]));
    endcase
  endfunction

  initial begin
    req = '0;
    req.wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ridx[i], q);
      chk(q, rval[i]);
    end
    bus(1'b0, 14'h0001, 16'h0000, q, r);
    chk(16'(r), 16'(jcmd_pkg::RESP_SLVERR));
    bus(1'b1, 14'h0001, 16'h1234, q, r);
    chk(16'(r), 16'(jcmd_pkg::RESP_SLVERR));
    wr(jcmd_pkg::IDX_RAW_STATUS, 16'hFFFF);
    rd(jcmd_pkg::IDX_RAW_STATUS, q);
    chk(q, 16'h0000);
    // clamp codes look at the conditioned sense pin level itself
    for (int c = 0; c < 16; c++) begin
      wr(jcmd_pkg::IDX_CLAMP_CTRL, 16'(c));
      for (int p = 0; p < 4; p++) begin
        jack <= p[1];
        gpio_pin <= p[0];
        repeat (8) @(posedge aclk);
        rd(jcmd_pkg::IDX_RAW_STATUS, q);
        if (c != 2 && c != 3) begin
          chk(16'(q[3]), 16'(clamp_exp(4'(c), p[1], p[0])));
          chk(16'(ana.clamp_short), 16'(clamp_exp(4'(c), p[1], p[0])));
        end
      end
    end
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        wr(jcmd_pkg::IDX_CLAMP_CTRL, 16'(c));
        wr(jcmd_pkg::IDX_SWITCH_CTRL, 16'(m));
        repeat (4) @(posedge aclk);
        chk(16'(ana.switch_closed), 16'(m == 1 || (m == 2 && c == 1) || (m == 3 && c == 0)));
      end
    end
    for (int k = 1; k < 3; k++) begin
      wr(jcmd_pkg::IDX_CLAMP_CTRL, 16'h0000);
      wr(jcmd_pkg::IDX_EVENT_MASK, 16'(k));
      r0 = rise_n;
      f0 = fall_n;
      wr(jcmd_pkg::IDX_CLAMP_CTRL, 16'h0001);
      repeat (8) @(posedge aclk);
      wr(jcmd_pkg::IDX_CLAMP_CTRL, 16'h0000);
      repeat (8) @(posedge aclk);
      chk(16'(rise_n - r0), 16'(k == 1));
      chk(16'(fall_n - f0), 16'(k == 2));
    end
    jack <= 1'b1;
    wr(jcmd_pkg::IDX_DEBOUNCE_CTRL, 16'h0009);
    wr(jcmd_pkg::IDX_CLAMP_CTRL, 16'h0004);
    jack <= 1'b0;
    repeat (20) @(posedge aclk);
    chk(16'(ana.clamp_short), 16'h0000);
    repeat (4) begin
      repeat (6) @(posedge aclk);
      clk32 <= 1'b1;
      repeat (6) @(posedge aclk);
      clk32 <= 1'b0;
    end
    repeat (8) @(posedge aclk);
    chk(16'(ana.clamp_short), 16'h0001);
    wr(jcmd_pkg::IDX_ACC_MODE, 16'h2000);
    wr(jcmd_pkg::IDX_MIC_DET2, 16'h00FF);
    wr(jcmd_pkg::IDX_MIC_DET1, 16'h0321);
    waitreq(1'b1, n);
    chk(16'(ana.sense_pin_select), 16'h0001);
    chk(16'(ana.detect_reference_select), 16'h0002);
    chk(16'(ana.bias_output_enable), 16'h0002);
    chk(16'(ana.level_enable_mask), 16'h009F);
    chk(16'(ana.adc_mode), 16'h0000);
    waitreq(1'b0, n);
    waitreq(1'b1, n);
    chk(16'(n >= 16 && n <= 17), 16'h0001);
    rd(jcmd_pkg::IDX_RESULT, q);
    chk(16'(q[0]), 16'h0000);
    waitreq(1'b0, n);
    repeat (2) @(posedge aclk);
    rd(jcmd_pkg::IDX_RESULT, q);
    chk(q, 16'h000F);
    wr(jcmd_pkg::IDX_MIC_DET1, 16'h0323);
    lvl <= 3'h5;
    repeat (3) begin
      waitreq(1'b1, n);
      waitreq(1'b0, n);
    end
    rd(jcmd_pkg::IDX_RESULT, q);
    chk(q, 16'h000F);
    waitreq(1'b1, n);
    waitreq(1'b0, n);
    rd(jcmd_pkg::IDX_RESULT, q);
    chk(q, 16'h0017);
    wr(jcmd_pkg::IDX_MIC_DET1, 16'h0000);
    wr(jcmd_pkg::IDX_ACC_MODE, 16'h0001);
    wr(jcmd_pkg::IDX_MIC_DET1, 16'h0001);
    repeat (60) @(posedge aclk);
    chk(16'(ana.meas_req), 16'h0000);
    wr(jcmd_pkg::IDX_MIC_DET1, 16'h0000);
    // one detect function at a time: mode moves only while detection is off
    wr(jcmd_pkg::IDX_ACC_MODE, 16'h0007);
    wr(jcmd_pkg::IDX_MIC_DET1, 16'h0001);
    waitreq(1'b1, n);
    chk(16'(ana.adc_mode), 16'h0001);
    chk(16'(ana.bias_output_enable), 16'h0000);
    waitreq(1'b0, n);
    adc_v <= 7'h28;
    q = 16'h0000;
    for (int k = 0; k < 40 && q[0] !== 1'b1; k++) begin
      rd(jcmd_pkg::IDX_RESULT, q);
    end
    chk(16'(q[0]), 16'h0001);
    wr(jcmd_pkg::IDX_MIC_DET1, 16'h0000);
    rd(jcmd_pkg::IDX_ADC_RESULT, q);
    chk(q, 16'hF828);
    wr(jcmd_pkg::IDX_ACC_MODE, 16'h0000);
    summarize();
  end
endmodule
